//--- rtl/charge_ctrl_map.vh
// register map, field positions and timing constants of the charge controller
`ifndef CHARGE_CTRL_MAP_VH
`define CHARGE_CTRL_MAP_VH
`define OFS_STATUS      4'h0
`define OFS_CONFIG      4'h4
`define OFS_IND_ON      4'h8
`define OFS_IND_PER     4'hC
`define CFG_USB_500     1
`define CFG_DISABLE     2
`define CFG_RED_LO      3
`define CFG_TIMER_EN    5
`define CFG_RESET       6
`define CFG_FAULT_CLR   7
`define CFG_RESET_VAL   8'h00
`define ST_TAPER_BIT    3
`define ST_TERM_BIT     4
`define ST_FAULT_BIT    5
`define IND_MODE_CHG    2'h0
`define IND_MODE_ON     2'h1
`define IND_MODE_OFF    2'h2
`define IND_MODE_BLINK  2'h3
`define USB_DELAY_US    32'd100
`define PRECHG_TIMEOUT_MS 48'd1800000
`define FAST_TIMEOUT_MS   48'd18000000
`define TAPER_TIMEOUT_MS  48'd1800000
`define CLK_MHZ         32'd125
`define BLINK_TICK_CYC  32'd1250000
`endif

//--- rtl/indicator_blink.v
// blink generator for the power-good indicator
`timescale 1ns/10ps
`default_nettype none
`include "charge_ctrl_map.vh"
module indicator_blink #(
  parameter TICK_CYC = `BLINK_TICK_CYC
) (
  input  wire       aclk,      // clock
  input  wire       aresetn,   // sync reset, low active
  input  wire [7:0] on_time,   // on ticks per period
  input  wire [7:0] period,    // ticks per period
  output reg        blink_on   // blink phase, high while lit
);
  reg [31:0] tick_reg;
  reg [7:0]  pos_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_reg <= 32'h0;
      pos_reg  <= 8'h00;
      blink_on <= 1'b0;
    end else begin
      if (tick_reg >= TICK_CYC - 1) begin
        tick_reg <= 32'h0;
        if (pos_reg + 8'h01 >= period)
          pos_reg <= 8'h00;
        else
          pos_reg <= pos_reg + 8'h01;
      end else begin
        tick_reg <= tick_reg + 32'h1;
      end
      blink_on <= (pos_reg < on_time);
    end
  end
endmodule
`default_nettype wire

//--- rtl/charge_ctrl.v
// charge sequencing, safety timers, power-good and AXI4-Lite registers
//
// Behaviour
// R1 - adapter input charges by default, usb when adapter absent, adapter wins
// R2 - usb current limit 100 mA after reset, host may raise to 500 mA
// R3 - charger fully off by host disable bit or usb port control
// R4 - usb charging starts only after a delay once usb turns valid
// R5 - adapter overvoltage comparator inhibits charging
// R6 - temperature out of window suspends at once, fet off, timers frozen
// R7 - temperature back in window resumes charging, timers continue
// R8 - low battery at start gives precharge at one tenth current
// R9 - precharge timer expiry turns charger off, sets fault, detection current
// R10 - fault cleared by reset, battery replacement or host
// R11 - two-bit field cuts adapter current in 25% steps, not usb
// R12 - fast timer expiry before taper gives fault and detection current
// R13 - fast-charge timer resets when forced out of voltage regulation
// R14 - fast and taper timers off after reset, run with config bit 5
// R15 - taper timer starts at taper current, ends charge, restarts above
// R16 - after termination, recharge when battery below recharge threshold
// R17 - fast and taper timers pause during thermal suspend
// R18 - current below termination threshold ends charging
// R19 - new battery restart clears taper and termination status bits
// R20 - power good when an input exceeds battery by 100 mV, not overvoltage
// R21 - power good high impedance while charger held in reset by bit 6
// R22 - power good from charger by default, indicator registers override
// R23 - exactly one charge phase active, shown in status bits
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "charge_ctrl_map.vh"
module charge_ctrl #(
  parameter USB_DELAY_CYC = `USB_DELAY_US * `CLK_MHZ,
  parameter PRECHG_CYC    = `PRECHG_TIMEOUT_MS * 48'd1000 * `CLK_MHZ,
  parameter FAST_CYC      = `FAST_TIMEOUT_MS * 48'd1000 * `CLK_MHZ,
  parameter TAPER_CYC     = `TAPER_TIMEOUT_MS * 48'd1000 * `CLK_MHZ,
  parameter BLINK_CYC     = `BLINK_TICK_CYC
) (
  input  wire        aclk,          // clock
  input  wire        aresetn,       // sync reset, low active
  input  wire [3:0]  s_axi_awaddr,  // write address
  input  wire        s_axi_awvalid, // write address valid
  output reg         s_axi_awready, // write address ready
  input  wire [31:0] s_axi_wdata,   // write data
  input  wire [3:0]  s_axi_wstrb,   // write strobes
  input  wire        s_axi_wvalid,  // write data valid
  output reg         s_axi_wready,  // write data ready
  output reg  [1:0]  s_axi_bresp,   // write response
  output reg         s_axi_bvalid,  // write response valid
  input  wire        s_axi_bready,  // write response ready
  input  wire [3:0]  s_axi_araddr,  // read address
  input  wire        s_axi_arvalid, // read address valid
  output reg         s_axi_arready, // read address ready
  output reg  [31:0] s_axi_rdata,   // read data
  output reg  [1:0]  s_axi_rresp,   // read response
  output reg         s_axi_rvalid,  // read data valid
  input  wire        s_axi_rready,  // read data ready
  input  wire        adapter_input_voltage, // adapter above battery+100mV
  input  wire        usb_valid,     // usb above battery+100mV
  input  wire        adapter_ovp,   // adapter above overvoltage threshold
  input  wire        usb_port_disable, // usb port control, charger off
  input  wire        cold_temp_threshold, // temp sense below cold limit
  input  wire        hot_temp_threshold,  // temp sense above hot limit
  input  wire        low_voltage_threshold, // battery below low limit
  input  wire        recharge_threshold,    // battery below recharge level
  input  wire        batt_at_reg_voltage,   // battery at regulation voltage
  input  wire        taper_detect,  // charge current below taper level
  input  wire        term_detect,   // charge current below termination
  input  wire        batt_replaced, // battery replacement seen
  input  wire        sleep_mode,    // device in sleep
  output reg         fet_on,        // power fet on
  output reg         src_adapter,   // adapter path selected
  output reg         src_usb,       // usb path selected
  output reg  [2:0]  current_sel,   // 0 off/detect,1 pre,2 usb100,3 usb500,
                                    // 4 adapter, cut given on adapter_red, 5-7 unused
  output reg  [1:0]  adapter_red,   // adapter reduction in 25% steps
  output reg         detect_current, // detection current only
  output reg         power_good_out,    // power-good pull low level
  output reg         power_good_out_oe  // power-good driver enable
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PRE  = 3'h1;
  localparam ST_FAST = 3'h2;
  localparam ST_VREG = 3'h3;
  localparam ST_DONE = 3'h4;
  localparam ST_SUSP = 3'h5;
  localparam ST_FLT  = 3'h6;

  reg [2:0]  state_reg, state_next, susp_ret_reg;
  reg [7:0]  charge_config_reg;
  reg [7:0]  indicator_on_time_reg;
  reg [7:0]  indicator_period_reg;
  reg [1:0]  ind_mode_reg;
  reg        fault_reg, taper_flag_reg, term_flag_reg;
  reg [31:0] usb_cnt_reg;
  reg [47:0] pre_cnt_reg, fast_cnt_reg, taper_cnt_reg; // half-hour to five-hour spans
  reg [3:0]  awaddr_reg;
  reg [31:0] wdata_reg;
  reg        aw_have_reg, w_have_reg;
  wire       blink_on;

  wire cfg_reset  = charge_config_reg[`CFG_RESET];
  wire timers_en  = charge_config_reg[`CFG_TIMER_EN]; // R14
  wire adapter_ok = adapter_input_voltage & ~adapter_ovp; // R5
  wire usb_ready  = usb_valid & (usb_cnt_reg >= USB_DELAY_CYC); // R4
  wire src_any    = adapter_ok | usb_ready; // R1
  wire disabled   = charge_config_reg[`CFG_DISABLE] | usb_port_disable
                    | cfg_reset; // R3
  wire temp_bad   = cold_temp_threshold | hot_temp_threshold;
  wire host_fclr  = aw_have_reg & w_have_reg & ~s_axi_bvalid
                    & (awaddr_reg == `OFS_CONFIG)
                    & wdata_reg[`CFG_FAULT_CLR];
  wire active     = (state_reg == ST_PRE) | (state_reg == ST_FAST)
                    | (state_reg == ST_VREG);
  wire [7:0] status = {2'b00, fault_reg, term_flag_reg, taper_flag_reg,
                       state_reg}; // R23

  // usb qualification delay
  always @(posedge aclk) begin
    if (!aresetn)
      usb_cnt_reg <= 32'h0;
    else if (!usb_valid)
      usb_cnt_reg <= 32'h0;
    else if (usb_cnt_reg < USB_DELAY_CYC)
      usb_cnt_reg <= usb_cnt_reg + 32'h1; // R4
  end

  // phase sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (src_any && !disabled && !temp_bad)
          state_next = low_voltage_threshold ? ST_PRE : ST_FAST; // R8
      end
      ST_PRE: begin
        if (!low_voltage_threshold)
          state_next = ST_FAST;
        else if (timers_en && pre_cnt_reg >= PRECHG_CYC - 1)
          state_next = ST_FLT; // R9
      end
      ST_FAST: begin
        if (term_detect)
          state_next = ST_DONE; // R18
        else if (batt_at_reg_voltage)
          state_next = ST_VREG;
        else if (timers_en && fast_cnt_reg >= FAST_CYC - 1)
          state_next = ST_FLT; // R12
      end
      ST_VREG: begin
        if (term_detect)
          state_next = ST_DONE; // R18
        else if (timers_en && taper_detect &&
                 taper_cnt_reg >= TAPER_CYC - 1)
          state_next = ST_DONE; // R15
        else if (!batt_at_reg_voltage)
          state_next = ST_FAST; // R13
        else if (timers_en && fast_cnt_reg >= FAST_CYC - 1 && !taper_detect)
          state_next = ST_FLT; // R12
      end
      ST_DONE: begin
        if (recharge_threshold)
          state_next = ST_IDLE; // R16
      end
      ST_SUSP: begin
        if (!temp_bad)
          state_next = susp_ret_reg; // R7
      end
      ST_FLT: begin
        if (batt_replaced || host_fclr)
          state_next = ST_IDLE; // R10
      end
      default: state_next = ST_IDLE;
    endcase
    if (active && temp_bad)
      state_next = ST_SUSP; // R6
    if ((disabled || !src_any) && state_reg != ST_FLT)
      state_next = ST_IDLE; // R3
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= ST_IDLE;
      susp_ret_reg   <= ST_FAST;
      fault_reg      <= 1'b0;
      taper_flag_reg <= 1'b0;
      term_flag_reg  <= 1'b0;
      pre_cnt_reg    <= 48'h0;
      fast_cnt_reg   <= 48'h0;
      taper_cnt_reg  <= 48'h0;
    end else begin
      state_reg <= state_next;
      if (active && state_next == ST_SUSP)
        susp_ret_reg <= state_reg; // R6
      if (state_next == ST_FLT && state_reg != ST_FLT)
        fault_reg <= 1'b1; // R9
      else if (batt_replaced || host_fclr)
        fault_reg <= 1'b0; // R10
      if (state_reg == ST_VREG && state_next == ST_DONE)
        taper_flag_reg <= ~term_detect;
      if ((state_reg == ST_FAST || state_reg == ST_VREG) && term_detect)
        term_flag_reg <= 1'b1; // R18
      else if (state_reg == ST_DONE && state_next == ST_IDLE) begin
        taper_flag_reg <= 1'b0; // R19
        term_flag_reg  <= 1'b0; // R19
      end
      // timers hold while suspended
      if (state_reg == ST_PRE && timers_en)
        pre_cnt_reg <= pre_cnt_reg + 48'h1;
      else if (state_reg != ST_SUSP)
        pre_cnt_reg <= 48'h0; // R17
      if (state_reg == ST_VREG && state_next == ST_FAST)
        fast_cnt_reg <= 48'h0; // R13
      else if ((state_reg == ST_FAST || state_reg == ST_VREG) && timers_en)
        fast_cnt_reg <= fast_cnt_reg + 48'h1; // R14
      else if (state_reg != ST_SUSP)
        fast_cnt_reg <= 48'h0; // R17
      if (state_reg == ST_VREG && taper_detect && timers_en)
        taper_cnt_reg <= taper_cnt_reg + 48'h1; // R15
      else if (state_reg != ST_SUSP)
        taper_cnt_reg <= 48'h0; // R15
    end
  end

  // power path outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      fet_on         <= 1'b0;
      src_adapter    <= 1'b0;
      src_usb        <= 1'b0;
      current_sel    <= 3'h0;
      adapter_red    <= 2'h0;
      detect_current <= 1'b0;
    end else begin
      fet_on      <= (state_next == ST_PRE) | (state_next == ST_FAST)
                     | (state_next == ST_VREG); // R6
      src_adapter <= adapter_ok; // R1
      src_usb     <= ~adapter_ok & usb_ready; // R1
      adapter_red <= adapter_ok ?
                     charge_config_reg[`CFG_RED_LO+1:`CFG_RED_LO] :
                     2'h0; // R11
      detect_current <= (state_next == ST_FLT); // R9
      if (state_next == ST_PRE)
        current_sel <= 3'h1; // R8
      else if (state_next != ST_FAST && state_next != ST_VREG)
        current_sel <= 3'h0;
      else if (adapter_ok)
        current_sel <= 3'h4;
      else
        current_sel <= charge_config_reg[`CFG_USB_500] ? 3'h3 : 3'h2; // R2
    end
  end

  // power-good indicator
  always @(posedge aclk) begin
    if (!aresetn) begin
      power_good_out    <= 1'b0;
      power_good_out_oe <= 1'b0;
    end else begin
      power_good_out <= 1'b0;
      if (cfg_reset || sleep_mode)
        power_good_out_oe <= 1'b0; // R21
      else
        case (ind_mode_reg)
          `IND_MODE_ON:    power_good_out_oe <= 1'b1; // R22
          `IND_MODE_OFF:   power_good_out_oe <= 1'b0; // R22
          `IND_MODE_BLINK: power_good_out_oe <= blink_on; // R22
          default: power_good_out_oe <= adapter_ok | usb_valid; // R20
        endcase
    end
  end

  indicator_blink #(
    .TICK_CYC (BLINK_CYC)
  ) u_blink (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .on_time  (indicator_on_time_reg),
    .period   (indicator_period_reg),
    .blink_on (blink_on)
  );

  // axi4-lite write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 4'h0;
      wdata_reg     <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      charge_config_reg     <= `CFG_RESET_VAL; // R14
      indicator_on_time_reg <= 8'h00;
      indicator_period_reg  <= 8'h00;
      ind_mode_reg          <= `IND_MODE_CHG; // R22
    end else begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (awaddr_reg)
          `OFS_CONFIG:
            charge_config_reg <= {1'b0, wdata_reg[6:0]};
          `OFS_IND_ON: indicator_on_time_reg <= wdata_reg[7:0];
          `OFS_IND_PER: begin
            indicator_period_reg <= wdata_reg[7:0];
            ind_mode_reg         <= wdata_reg[9:8];
          end
          `OFS_STATUS: ;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end
    end
  end

  // axi4-lite read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `OFS_STATUS:  s_axi_rdata <= {24'h0, status}; // R23
          `OFS_CONFIG:  s_axi_rdata <= {24'h0, charge_config_reg};
          `OFS_IND_ON:  s_axi_rdata <= {24'h0, indicator_on_time_reg};
          `OFS_IND_PER:
            s_axi_rdata <= {22'h0, ind_mode_reg, indicator_period_reg};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/pg_pull_up.sv
// pull-up model of the open-drain power-good pin
`timescale 1ns/10ps
`default_nettype none
module pg_pull_up (
  input  wire logic power_good_out,    // pin level when driven
  input  wire logic power_good_out_oe, // driver enable
  output wire logic pg_pin             // resolved pin
);
  // a released pin floats up to the pull-up
  assign pg_pin = power_good_out_oe ? power_good_out : 1'b1;
endmodule
`default_nettype wire

//--- verif/charge_ctrl_properties.sv
// assertion checker bound to the charge controller
`timescale 1ns/10ps
`default_nettype none
module charge_ctrl_checker #(
  parameter USB_DELAY_CYC = 8
) (
  input wire logic       aclk,                // clock
  input wire logic       aresetn,             // reset, low
  input wire logic       s_axi_arvalid,       // read addr valid
  input wire logic       s_axi_arready,       // read addr ready
  input wire logic       s_axi_rvalid,        // read data valid
  input wire logic       usb_valid,           // usb present
  input wire logic       adapter_ovp,         // adapter overvoltage
  input wire logic       usb_port_disable,    // usb port off
  input wire logic       cold_temp_threshold, // too cold
  input wire logic       hot_temp_threshold,  // too hot
  input wire logic       sleep_mode,          // sleep
  input wire logic       fet_on,              // power fet
  input wire logic       src_adapter,         // adapter path
  input wire logic       src_usb,             // usb path
  input wire logic [2:0] current_sel,         // current level
  input wire logic [1:0] adapter_red,         // adapter cut
  input wire logic       detect_current,      // detect only
  input wire logic       power_good_out,      // pin level
  input wire logic       power_good_out_oe    // pin enable
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [15:0] usb_age_reg;
  // cycles since usb turned valid
  always_ff @(posedge aclk) begin
    if (!aresetn || !usb_valid)
      usb_age_reg <= 16'h0000;
    else if (usb_age_reg != 16'hFFFF)
      usb_age_reg <= usb_age_reg + 16'h0001;
  end
  a_source_onehot:
    assert property (!(src_adapter && src_usb))
    else $error("both sources selected");
  a_usb_wait:
    assert property ((usb_age_reg <= USB_DELAY_CYC) |-> !(fet_on && src_usb))
    else $error("usb charging before delay");
  a_usb_limit:
    assert property (fet_on && src_usb
      |-> current_sel inside {3'h1, 3'h2, 3'h3})
    else $error("usb current out of range");
  a_usb_no_cut:
    assert property (src_usb |-> adapter_red == 2'h0)
    else $error("reduction applied on usb");
  a_ovp_inhibit:
    assert property ((adapter_ovp && !usb_valid) [*3] |-> !fet_on)
    else $error("charging at overvoltage");
  a_port_off:
    assert property (usb_port_disable [*3] |-> !fet_on)
    else $error("charging while port disabled");
  a_temp_suspend:
    assert property ((cold_temp_threshold || hot_temp_threshold) [*3]
      |-> !fet_on)
    else $error("charging out of temperature");
  a_detect_fet:
    assert property (detect_current |-> !fet_on)
    else $error("fet on in fault");
  a_pg_sleep:
    assert property (sleep_mode [*3] |-> !power_good_out_oe)
    else $error("power good driven in sleep");
  a_pg_level:
    assert property (!power_good_out)
    else $error("power good driven high");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind charge_ctrl charge_ctrl_checker #(.USB_DELAY_CYC(USB_DELAY_CYC))
  CHK (.*);
`default_nettype wire

//--- verif/charge_ctrl_tb.sv
// self-checking bench of the charge controller
`timescale 1ns/10ps
`default_nettype none
module charge_ctrl_tb;
  localparam int PRE = 30;
  localparam int FAST = 80;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, adapter_red, rrsp, brsp;
  logic [2:0] current_sel;
  logic adapter_input_voltage, usb_valid, adapter_ovp, usb_port_disable;
  logic cold_temp_threshold, hot_temp_threshold, low_voltage_threshold;
  logic recharge_threshold, batt_at_reg_voltage, taper_detect, term_detect;
  logic batt_replaced, sleep_mode, fet_on, src_adapter, src_usb;
  logic detect_current, power_good_out, power_good_out_oe;
  wire logic pg_pin;
  int mismatches, n_tests, cyc, lo;
  charge_ctrl #(.USB_DELAY_CYC(8), .PRECHG_CYC(PRE), .FAST_CYC(FAST),
    .TAPER_CYC(20), .BLINK_CYC(2)) DUT (.*);
  pg_pull_up PEER (.*);
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out;
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (aw || w || s_axi_bvalid !== 1'b1) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && aw) s_axi_awvalid <= 0;
      if (s_axi_awready === 1'b1) aw = 0;
      if (s_axi_wready === 1'b1 && w) s_axi_wvalid <= 0;
      if (s_axi_wready === 1'b1) w = 0;
    end
    brsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task st(input logic [31:0] e);
    rd(4'h0);
    chk(rdat & 32'h3F, e);
  endtask
  task sc_regs;
    rd(4'h4);
    chk(rdat, 32'h0);
    rd(4'h2);
    chk(rrsp, 2'h2);
    wr(4'h0, 32'hFF);
    chk(brsp, 2'h0);
    wr(4'h2, 32'h1);
    chk(brsp, 2'h2);
    st(32'h0);
  endtask
  task sc_supply;
    usb_valid <= 1;
    tick(4);
    chk(fet_on, 0);
    tick(12);
    chk({fet_on, src_usb, current_sel}, 5'h1A);
    wr(4'h4, 32'h02);
    tick(3);
    chk(current_sel, 3'h3);
    adapter_input_voltage <= 1;
    tick(4);
    chk({fet_on, src_adapter, src_usb, current_sel}, 6'h34);
    wr(4'h4, 32'h10);
    tick(3);
    chk(adapter_red, 2'h2);
    adapter_input_voltage <= 0;
    tick(4);
    chk({src_usb, adapter_red}, 3'h4);
    usb_port_disable <= 1;
    tick(4);
    chk(fet_on, 0);
    usb_port_disable <= 0;
    wr(4'h4, 32'h04);
    tick(3);
    chk(fet_on, 0);
    wr(4'h4, 32'h0);
    usb_valid <= 0;
    adapter_input_voltage <= 1;
    adapter_ovp <= 1;
    tick(4);
    chk({fet_on, power_good_out_oe}, 2'h0);
    adapter_ovp <= 0;
  endtask
  task sc_precharge;
    adapter_input_voltage <= 0;
    low_voltage_threshold <= 1;
    wr(4'h4, 32'h20);
    adapter_input_voltage <= 1;
    tick(4);
    chk({fet_on, current_sel}, 4'h9);
    tick(PRE + 4);
    chk({fet_on, detect_current}, 2'h1);
    st(32'h26);
    low_voltage_threshold <= 0;
    wr(4'h4, 32'hA0);
    st(32'h02);
  endtask
  task sc_thermal;
    adapter_input_voltage <= 0;
    tick(3);
    adapter_input_voltage <= 1;
    tick(FAST - 20);
    hot_temp_threshold <= 1;
    tick(3);
    chk(fet_on, 0);
    st(32'h05);
    tick(2 * FAST);
    hot_temp_threshold <= 0;
    tick(3);
    chk(fet_on, 1);
    st(32'h02);
    tick(25);
    chk({fet_on, detect_current}, 2'h1);
    st(32'h26);
    batt_replaced <= 1;
    tick(1);
    batt_replaced <= 0;
    st(32'h02);
  endtask
  task sc_taper;
    batt_at_reg_voltage <= 1;
    tick(2);
    st(32'h03);
    taper_detect <= 1;
    tick(10);
    taper_detect <= 0;
    tick(3);
    taper_detect <= 1;
    tick(12);
    st(32'h03);
    tick(10);
    st(32'h0C);
    batt_at_reg_voltage <= 0;
    taper_detect <= 0;
    recharge_threshold <= 1;
    tick(3);
    st(32'h02);
    recharge_threshold <= 0;
    batt_at_reg_voltage <= 1;
    term_detect <= 1;
    tick(3);
    st(32'h14);
    term_detect <= 0;
    batt_at_reg_voltage <= 0;
  endtask
  task sc_pg;
    tick(3);
    chk(pg_pin, 0);
    sleep_mode <= 1;
    tick(3);
    chk(pg_pin, 1);
    sleep_mode <= 0;
    wr(4'h4, 32'h40);
    tick(3);
    chk({pg_pin, power_good_out_oe}, 2'h2);
    wr(4'h4, 32'h0);
    wr(4'hC, 32'h200);
    tick(3);
    chk(pg_pin, 1);
    adapter_input_voltage <= 0;
    wr(4'hC, 32'h100);
    tick(3);
    chk(pg_pin, 0);
    wr(4'h8, 32'h1);
    wr(4'hC, 32'h304);
    tick(2);
    lo = 0;
    repeat (32) begin
      @(posedge aclk);
      lo += (pg_pin === 1'b0);
    end
    chk(lo, 8);
    wr(4'hC, 32'h0);
    tick(3);
    chk(pg_pin, 1);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {adapter_input_voltage, usb_valid, adapter_ovp, usb_port_disable} = '0;
    {cold_temp_threshold, hot_temp_threshold, low_voltage_threshold} = '0;
    {recharge_threshold, batt_at_reg_voltage, taper_detect} = '0;
    {term_detect, batt_replaced, sleep_mode} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 0;
    tick(4);
    aresetn <= 1;
    sc_regs;
    sc_supply;
    sc_precharge;
    sc_thermal;
    sc_taper;
    sc_pg;
    close_out;
  end
endmodule
`default_nettype wire
